// ---- wp_startup.sv ----
/*
 * Register write protection plus start-up sequencing: self check, fuse
 * load through SEC-DED, standby, active and failsafe.
 * Assumes a byte register port already decoded from the serial interface,
 * and run/low-power pins asynchronous to clk_i.
 */
//
// Functional notes
// - Group locked only if set in both locks
// - Lock bits: order,channel,irq,config,status,control
// - Locks apply only to bank one
// - Fixed register to group membership map
// - Channel select bits 7..0 map channels 8..1
// - Channel select resets to all ones
// - Lock registers reset to zero
// - Lock bits once set stay set until unlock-all
// - Unlock-all bit clears both locks
// - Locked control group blocks unlock-all
// - Powerup self check only if bit set
// - Run fall runs check if shutdown bit
// - Fuse load corrects single, flags double errors
// - During check: irq released, reset asserted, bus off
// - Good check: bus on, load, standby
// - Failure or double error: failsafe, assert outputs
// - Done flag, done irq, done status bit
// - Outputs after check follow result and enables
// - Four-bit result field reports outcome
// - Run rise starts order timeout timer
// - Low-power pin ignored until timeout expires
// - Standby when run low and check done
`timescale 1ns/1ns
module wp_startup #(
	parameter int CHECK_LEN = 64
) (
	input wire logic clk_i,
	input wire logic reset_out_n_i,
	input wire logic bank_one_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic check_fail_i,
	input wire logic run_req_i,
	input wire logic low_power_n_i,
	output logic [7:0] rdata_o,
	output logic bus_active_o,
	output logic fault_irq_n_o,
	output logic fault_irq_n_oe_o,
	output logic reset_out_n_o,
	output logic reset_out_n_oe_o,
	output logic tag_oe_o,
	output logic standby_o,
	output logic slow_ov_only_o,
	output logic timer_run_o,
	output logic sleep_entry_o,
	output logic sleep_exit_o
);
	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// Syndrome decode for a 13-bit word: parity in bit 12, checks 11:8
	function automatic logic [12:0] secded(input logic [12:0] w);
		logic [3:0] syn;
		logic par;
		logic [7:0] d;
		syn = 4'h0;
		d = w[7:0];
		syn[0] = w[8] ^ d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
		syn[1] = w[9] ^ d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
		syn[2] = w[10] ^ d[1] ^ d[2] ^ d[3] ^ d[7];
		syn[3] = w[11] ^ d[4] ^ d[5] ^ d[6] ^ d[7];
		par = ^w;
		// Returns {double, single, data}
		if (syn != 4'h0 && !par) begin
			secded = {1'b1, 1'b0, 3'b000, d};
		end else if (par) begin
			case (syn)
				4'h3: d[0] = ~d[0];
				4'h5: d[1] = ~d[1];
				4'h6: d[2] = ~d[2];
				4'h7: d[3] = ~d[3];
				4'h9: d[4] = ~d[4];
				4'hA: d[5] = ~d[5];
				4'hB: d[6] = ~d[6];
				4'hC: d[7] = ~d[7];
				default: d = d;
			endcase
			secded = {1'b0, 1'b1, 3'b000, d};
		end else begin
			secded = {5'b00000, d};
		end
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] run_sync_reg;
	logic [2:0] lp_sync_reg;
	logic run_reg;
	logic lp_reg;
	logic run_next;
	logic lp_next;

	// Change accepted only when second and third stages agree
	always_comb begin
		run_next = (run_sync_reg[1] == run_sync_reg[2]) ? run_sync_reg[2] : run_reg;
		lp_next = (lp_sync_reg[1] == lp_sync_reg[2]) ? lp_sync_reg[2] : lp_reg;
	end

	always_ff @(posedge clk_i) begin
		if (!reset_out_n_i) begin
			run_sync_reg <= 3'b000;
			lp_sync_reg <= 3'b111;
			run_reg <= 1'b0;
			lp_reg <= 1'b1;
		end else begin
			run_sync_reg <= {run_sync_reg[1:0], run_req_i};
			lp_sync_reg <= {lp_sync_reg[1:0], low_power_n_i};
			run_reg <= run_next;
			lp_reg <= lp_next;
		end
	end

	// ------------------------------------------------------------
	// Registers and protection
	// ------------------------------------------------------------
	logic [7:0] lock_a_reg, lock_a_next, lock_b_reg, lock_b_next;
	logic [7:0] chsel_reg, chsel_next, ctrl_reg, ctrl_next, misc_reg, misc_next;
	logic [7:0] setup_reg, setup_next, ten_reg, ten_next, flags_reg, flags_next;
	logic [7:0] tout_hi_reg, tout_hi_next, tout_lo_reg, tout_lo_next;
	logic [7:0] result_reg, result_next;
	logic [7:0] rdata_reg, rdata_next;
	// One stored byte per channel; all offsets of a channel alias onto it
	logic [7:0] chan_reg [8];
	logic [7:0] chan_next [8];
	wp_pkg::mode_e state_reg, state_next;
	logic check_done_reg, check_done_next;
	logic [7:0] locked;
	logic [4:0] group;
	logic [2:0] chan;
	logic is_chan;
	logic prot;
	logic wr_ok;
	logic done_evt;
	logic fail_evt;

	assign locked = lock_a_reg & lock_b_reg;
	assign is_chan = addr_i >= wp_pkg::OFS_CHAN_FIRST && addr_i <= wp_pkg::OFS_CHAN_LAST;
	assign chan = 3'((addr_i - wp_pkg::OFS_CHAN_FIRST) >> wp_pkg::CHAN_SHIFT);

	// Group lookup; vendor control and bank select fall through unprotected
	always_comb begin
		group = 5'd31;
		if (addr_i == wp_pkg::OFS_SUPERVISOR_CTRL) begin
			group = 5'(wp_pkg::LOCK_CONTROL);
		end else if (addr_i == wp_pkg::OFS_SUPERVISOR_MISC || addr_i == wp_pkg::OFS_SELFTEST_SETUP
			|| addr_i == wp_pkg::OFS_CHANNEL_ENABLES || addr_i == wp_pkg::OFS_RANGE_SCALE) begin
			group = 5'(wp_pkg::LOCK_CONFIG);
		end else if ((addr_i >= wp_pkg::OFS_IRQ_EN_FIRST && addr_i <= wp_pkg::OFS_IRQ_EN_LAST)
			|| addr_i == wp_pkg::OFS_AUTOMASK_UP || addr_i == wp_pkg::OFS_AUTOMASK_DOWN) begin
			group = 5'(wp_pkg::LOCK_IRQ_ENABLE);
		end else if (addr_i >= wp_pkg::OFS_ORDER_TIMEOUT_HI && addr_i <= wp_pkg::OFS_DOWN_THRESHOLD_SELECT) begin
			group = 5'(wp_pkg::LOCK_RAIL_ORDER);
		end else if (is_chan) begin
			group = 5'(wp_pkg::LOCK_CHANNEL);
		end
	end

	// Channel settings lock only for selected channels
	always_comb begin
		prot = 1'b0;
		if (bank_one_i && group != 5'd31) begin
			if (group == 5'(wp_pkg::LOCK_CHANNEL)) begin
				prot = locked[wp_pkg::LOCK_CHANNEL] & chsel_reg[chan];
			end else begin
				prot = locked[group[2:0]];
			end
		end
	end

	assign wr_ok = wr_i && bus_active_o && !prot;

	// Register next values
	always_comb begin
		lock_a_next = lock_a_reg;
		lock_b_next = lock_b_reg;
		chsel_next = chsel_reg;
		ctrl_next = ctrl_reg;
		misc_next = misc_reg;
		setup_next = setup_reg;
		ten_next = ten_reg;
		flags_next = flags_reg;
		tout_hi_next = tout_hi_reg;
		tout_lo_next = tout_lo_reg;
		rdata_next = rdata_reg;
		chan_next = chan_reg;
		if (wr_ok) begin
			if (addr_i == wp_pkg::OFS_WRITE_LOCK_A) begin
				lock_a_next = lock_a_reg | (wdata_i & wp_pkg::LOCK_MASK);
			end else if (addr_i == wp_pkg::OFS_WRITE_LOCK_B) begin
				lock_b_next = lock_b_reg | (wdata_i & wp_pkg::LOCK_MASK);
			end else if (addr_i == wp_pkg::OFS_CHANNEL_LOCK_SELECT) begin
				chsel_next = wdata_i;
			end else if (addr_i == wp_pkg::OFS_SUPERVISOR_CTRL) begin
				ctrl_next = wdata_i & ~(8'h01 << wp_pkg::CTRL_UNLOCK_ALL);
				// Blocked by prot when control group locked
				if (wdata_i[wp_pkg::CTRL_UNLOCK_ALL]) begin
					lock_a_next = wp_pkg::LOCK_RESET;
					lock_b_next = wp_pkg::LOCK_RESET;
				end
			end else if (addr_i == wp_pkg::OFS_SUPERVISOR_MISC) begin
				misc_next = wdata_i;
			end else if (addr_i == wp_pkg::OFS_SELFTEST_SETUP) begin
				setup_next = wdata_i;
			end else if (addr_i == wp_pkg::OFS_SELFTEST_IRQ_ENABLES) begin
				ten_next = wdata_i;
			end else if (addr_i == wp_pkg::OFS_SELFTEST_FLAGS) begin
				flags_next = flags_reg & ~wdata_i;
			end else if (addr_i == wp_pkg::OFS_ORDER_TIMEOUT_HI) begin
				tout_hi_next = wdata_i;
			end else if (addr_i == wp_pkg::OFS_ORDER_TIMEOUT_LO) begin
				tout_lo_next = wdata_i;
			end else if (is_chan) begin
				chan_next[chan] = wdata_i;
			end
		end
		// Hardware set wins over a clear in the same cycle
		if (done_evt) begin
			flags_next[wp_pkg::TEN_DONE] = 1'b1;
			flags_next[wp_pkg::TEN_RESULT] = flags_next[wp_pkg::TEN_RESULT] | fail_evt;
		end
		if (rd_i && bus_active_o) begin
			if (addr_i == wp_pkg::OFS_WRITE_LOCK_A) begin
				rdata_next = lock_a_reg;
			end else if (addr_i == wp_pkg::OFS_WRITE_LOCK_B) begin
				rdata_next = lock_b_reg;
			end else if (addr_i == wp_pkg::OFS_CHANNEL_LOCK_SELECT) begin
				rdata_next = chsel_reg;
			end else if (addr_i == wp_pkg::OFS_SUPERVISOR_CTRL) begin
				rdata_next = ctrl_reg;
			end else if (addr_i == wp_pkg::OFS_SELFTEST_SETUP) begin
				rdata_next = setup_reg;
			end else if (addr_i == wp_pkg::OFS_SELFTEST_IRQ_ENABLES) begin
				rdata_next = ten_reg;
			end else if (addr_i == wp_pkg::OFS_SELFTEST_FLAGS) begin
				rdata_next = flags_reg;
			end else if (addr_i == wp_pkg::OFS_SUPERVISOR_STATUS) begin
				rdata_next = {6'h00, state_reg == wp_pkg::ST_FAILSAFE, check_done_reg};
			end else if (addr_i == wp_pkg::OFS_SELFTEST_RESULT) begin
				rdata_next = result_reg;
			end else if (addr_i == wp_pkg::OFS_SUPERVISOR_MISC) begin
				rdata_next = misc_reg;
			end else if (is_chan) begin
				rdata_next = chan_reg[chan];
			end else begin
				rdata_next = 8'h00;
			end
		end
	end

	// ------------------------------------------------------------
	// Start-up state machine
	// ------------------------------------------------------------
	logic [15:0] cnt_reg, cnt_next;
	logic [3:0] faddr_reg, faddr_next;
	logic first_reg, first_next;
	logic irq_reg, irq_next, rst_reg, rst_next;
	logic tout_reg, tout_next, run_d_reg, lp_d_reg;
	logic [23:0] tcnt_reg, tcnt_next;
	logic [12:0] fword;
	logic [12:0] fdec;

	wp_fuse_store #(.DEPTH(wp_pkg::FUSE_WORDS), .AW(4)) u_fuse (
		.clk_i(clk_i),
		.addr_i(faddr_reg),
		.data_o(fword)
	);

	assign fdec = secded(fword);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		faddr_next = faddr_reg;
		check_done_next = check_done_reg;
		first_next = 1'b0;
		irq_next = irq_reg;
		rst_next = rst_reg;
		result_next = result_reg;
		done_evt = 1'b0;
		fail_evt = 1'b0;
		case (state_reg)
			wp_pkg::ST_CHECK: begin
				// Irq released, reset held, bus idle
				irq_next = 1'b0;
				rst_next = 1'b1;
				if (first_reg && !setup_reg[wp_pkg::SETUP_CHECK_AT_POWERUP]) begin
					state_next = wp_pkg::ST_LOAD;
					rst_next = 1'b0;
					faddr_next = 4'h0;
				end else if (cnt_reg == 16'(CHECK_LEN - 1) || check_fail_i) begin
					done_evt = 1'b1;
					fail_evt = check_fail_i;
					check_done_next = 1'b1;
					result_next[wp_pkg::RES_CHECK_RAN] = 1'b1;
					result_next[wp_pkg::RES_CHECK_FAIL] = check_fail_i;
					// Pins follow result and enables
					irq_next = ten_reg[wp_pkg::TEN_DONE] | (check_fail_i & ten_reg[wp_pkg::TEN_RESULT]);
					rst_next = check_fail_i & ten_reg[wp_pkg::TEN_RESULT];
					state_next = check_fail_i ? wp_pkg::ST_FAILSAFE : wp_pkg::ST_LOAD;
					faddr_next = 4'h0;
					cnt_next = 16'h0000;
				end else begin
					cnt_next = cnt_reg + 16'h0001;
				end
			end
			wp_pkg::ST_LOAD: begin
				// Bus already active here
				cnt_next = cnt_reg + 16'h0001;
				if (cnt_reg != 16'h0000) begin
					result_next[wp_pkg::RES_SINGLE] = result_reg[wp_pkg::RES_SINGLE] | fdec[11];
					faddr_next = faddr_reg + 4'h1;
					if (fdec[12]) begin
						result_next[wp_pkg::RES_DOUBLE] = 1'b1;
						irq_next = 1'b1;
						rst_next = 1'b1;
						state_next = wp_pkg::ST_FAILSAFE;
					end else if (faddr_reg == 4'(wp_pkg::FUSE_WORDS - 1)) begin
						check_done_next = 1'b1;
						state_next = wp_pkg::ST_STANDBY;
					end
				end
			end
			wp_pkg::ST_STANDBY: begin
				if (run_reg) begin
					state_next = wp_pkg::ST_ACTIVE;
				end
			end
			wp_pkg::ST_ACTIVE: begin
				if (!run_reg) begin
					// Shutdown check on leaving active
					if (setup_reg[wp_pkg::SETUP_CHECK_AT_SHUTDOWN]) begin
						state_next = wp_pkg::ST_CHECK;
						cnt_next = 16'h0000;
						// Pins take check levels on entry, not one cycle late
						irq_next = 1'b0;
						rst_next = 1'b1;
					end else begin
						state_next = wp_pkg::ST_STANDBY;
					end
				end
			end
			default: begin
				// Failsafe holds both outputs until power cycle
				irq_next = 1'b1;
				rst_next = 1'b1;
			end
		endcase
	end

	// Order timeout timer and low-power qualification
	always_comb begin
		tcnt_next = tcnt_reg;
		tout_next = tout_reg;
		if (!run_reg) begin
			tout_next = 1'b0;
			tcnt_next = 24'h000000;
		end else if (!run_d_reg) begin
			tcnt_next = 24'({tout_hi_reg, tout_lo_reg}) * 24'(wp_pkg::TIMEOUT_UNIT_CYCLES);
			tout_next = 1'b0;
		end else if (tcnt_reg != 24'h000000) begin
			tcnt_next = tcnt_reg - 24'h000001;
		end else begin
			tout_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_out_n_i) begin
			lock_a_reg <= wp_pkg::LOCK_RESET;
			lock_b_reg <= wp_pkg::LOCK_RESET;
			chsel_reg <= wp_pkg::CHANNEL_LOCK_RESET;
			ctrl_reg <= 8'h00;
			misc_reg <= 8'h00;
			setup_reg <= wp_pkg::SETUP_RESET;
			ten_reg <= wp_pkg::TEN_RESET;
			flags_reg <= 8'h00;
			tout_hi_reg <= 8'h00;
			tout_lo_reg <= 8'h00;
			result_reg <= 8'h00;
			chan_reg <= '{default: 8'h00};
			rdata_reg <= 8'h00;
			state_reg <= wp_pkg::ST_CHECK;
			cnt_reg <= 16'h0000;
			faddr_reg <= 4'h0;
			check_done_reg <= 1'b0;
			first_reg <= 1'b1;
			irq_reg <= 1'b0;
			rst_reg <= 1'b1;
			tcnt_reg <= 24'h000000;
			tout_reg <= 1'b0;
			run_d_reg <= 1'b0;
			lp_d_reg <= 1'b1;
		end else begin
			lock_a_reg <= lock_a_next;
			lock_b_reg <= lock_b_next;
			chsel_reg <= chsel_next;
			ctrl_reg <= ctrl_next;
			misc_reg <= misc_next;
			setup_reg <= setup_next;
			ten_reg <= ten_next;
			flags_reg <= flags_next;
			tout_hi_reg <= tout_hi_next;
			tout_lo_reg <= tout_lo_next;
			result_reg <= result_next;
			chan_reg <= chan_next;
			rdata_reg <= rdata_next;
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			faddr_reg <= faddr_next;
			check_done_reg <= check_done_next;
			first_reg <= first_next;
			irq_reg <= irq_next;
			rst_reg <= rst_next;
			tcnt_reg <= tcnt_next;
			tout_reg <= tout_next;
			run_d_reg <= run_reg;
			lp_d_reg <= lp_reg;
		end
	end

	// ------------------------------------------------------------
	// Outputs from flip-flops; fault_irq_n_o and reset_out_n_o tied low
	// ------------------------------------------------------------
	logic [8:0] out_reg;
	logic [8:0] out_next;

	// Sleep edges honoured only once timeout has expired
	always_comb begin
		out_next[0] = state_next != wp_pkg::ST_CHECK;
		out_next[1] = state_next == wp_pkg::ST_STANDBY;
		out_next[2] = state_next == wp_pkg::ST_STANDBY;
		out_next[3] = run_reg && !tout_next;
		out_next[4] = run_reg && tout_reg && lp_d_reg && !lp_reg;
		out_next[5] = run_reg && tout_reg && !lp_d_reg && lp_reg;
		out_next[6] = state_next != wp_pkg::ST_CHECK; // tag pin released in check
		out_next[7] = irq_next;
		out_next[8] = rst_next;
	end

	always_ff @(posedge clk_i) begin
		if (!reset_out_n_i) begin
			out_reg <= 9'h100;
		end else begin
			out_reg <= out_next;
		end
	end

	assign bus_active_o = out_reg[0];
	assign standby_o = out_reg[1];
	assign slow_ov_only_o = out_reg[2];
	assign timer_run_o = out_reg[3];
	assign sleep_entry_o = out_reg[4];
	assign sleep_exit_o = out_reg[5];
	assign tag_oe_o = out_reg[6];
	assign fault_irq_n_o = 1'b0;
	assign fault_irq_n_oe_o = out_reg[7];
	assign reset_out_n_o = 1'b0;
	assign reset_out_n_oe_o = out_reg[8];
	assign rdata_o = rdata_reg;
endmodule

// ---- wp_pkg.sv ----
/*
 * Shared constants for the write-protect and start-up block.
 * Assumes a byte-wide register port with bank select and an 8-bit offset.
 */
package wp_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_WRITE_LOCK_A = 8'hF1;
	localparam logic [7:0] OFS_WRITE_LOCK_B = 8'hF2;
	localparam logic [7:0] OFS_CHANNEL_LOCK_SELECT = 8'hF3;
	localparam logic [7:0] OFS_SUPERVISOR_CTRL = 8'h10;
	localparam logic [7:0] OFS_SUPERVISOR_MISC = 8'h11;
	localparam logic [7:0] OFS_SELFTEST_SETUP = 8'h12;
	localparam logic [7:0] OFS_CHANNEL_ENABLES = 8'h1E;
	localparam logic [7:0] OFS_RANGE_SCALE = 8'h1F;
	localparam logic [7:0] OFS_IRQ_EN_FIRST = 8'h20;
	localparam logic [7:0] OFS_IRQ_EN_LAST = 8'h25;
	localparam logic [7:0] OFS_SELFTEST_IRQ_ENABLES = 8'h24;
	localparam logic [7:0] OFS_AUTOMASK_UP = 8'h26;
	localparam logic [7:0] OFS_AUTOMASK_DOWN = 8'h27;
	localparam logic [7:0] OFS_ORDER_TIMEOUT_HI = 8'h28;
	localparam logic [7:0] OFS_ORDER_TIMEOUT_LO = 8'h29;
	localparam logic [7:0] OFS_UP_THRESHOLD_SELECT = 8'h2A;
	localparam logic [7:0] OFS_DOWN_THRESHOLD_SELECT = 8'h2B;
	localparam logic [7:0] OFS_SELFTEST_FLAGS = 8'h2C;
	localparam logic [7:0] OFS_SUPERVISOR_STATUS = 8'h2D;
	localparam logic [7:0] OFS_SELFTEST_RESULT = 8'h2E;
	localparam logic [7:0] OFS_CHAN_FIRST = 8'h30;
	localparam logic [7:0] OFS_CHAN_LAST = 8'h6F;
	localparam int CHAN_SHIFT = 3;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int LOCK_RAIL_ORDER = 0;
	localparam int LOCK_CHANNEL = 1;
	localparam int LOCK_IRQ_ENABLE = 2;
	localparam int LOCK_CONFIG = 3;
	localparam int LOCK_STATUS = 4;
	localparam int LOCK_CONTROL = 5;
	localparam logic [7:0] LOCK_MASK = 8'h3F;
	localparam int CTRL_UNLOCK_ALL = 3;
	localparam int SETUP_CHECK_AT_POWERUP = 0;
	localparam int SETUP_CHECK_AT_SHUTDOWN = 1;
	localparam int TEN_DONE = 0;
	localparam int TEN_RESULT = 1;
	localparam int STAT_DONE = 0;
	localparam int STAT_FAILSAFE = 1;
	localparam int RES_SINGLE = 0;
	localparam int RES_DOUBLE = 1;
	localparam int RES_CHECK_FAIL = 2;
	localparam int RES_CHECK_RAN = 3;

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0] LOCK_RESET = 8'h00;
	localparam logic [7:0] CHANNEL_LOCK_RESET = 8'hFF;
	localparam logic [7:0] SETUP_RESET = 8'h01;
	localparam logic [7:0] TEN_RESET = 8'h03;
	localparam int FUSE_WORDS = 16;
	localparam logic [15:0] CHECK_CYCLES = 16'h0040;
	localparam logic [15:0] TIMEOUT_UNIT_CYCLES = 16'h00FA;

	typedef enum logic [2:0] {ST_CHECK, ST_LOAD, ST_STANDBY, ST_ACTIVE, ST_FAILSAFE} mode_e;

endpackage

// ---- wp_fuse_store.sv ----
/*
 * Fuse storage model: word array with registered read data, 13-bit words
 * (8 data + 5 check). Assumes contents are programmed by initial values.
 */
`timescale 1ns/1ns
module wp_fuse_store #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk_i,
	input wire logic [AW-1:0] addr_i,
	output logic [12:0] data_o
);
	logic [12:0] mem [DEPTH];
	logic [12:0] data_reg;

	// Blank fuses read as zero, which is a valid codeword
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem[i] = 13'h0000;
		end
	end

	// Registered read keeps the fuse path off the decode path
	always_ff @(posedge clk_i) begin
		data_reg <= mem[addr_i];
	end

	assign data_o = data_reg;
endmodule

// ---- wp_startup_asserts.sv ----
/*
 * Port checker for wp_startup: lock shadow, start-up outputs, run timer.
 * Assumes one clock and the synchronous active-low reset of the design.
 */
`timescale 1ns/1ns
module wp_startup_chk #(
	parameter int CHECK_LEN = 64
) (
	input wire logic clk_i,
	input wire logic reset_out_n_i,
	input wire logic bank_one_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic check_fail_i,
	input wire logic run_req_i,
	input wire logic [7:0] rdata_o,
	input wire logic bus_active_o,
	input wire logic fault_irq_n_oe_o,
	input wire logic reset_out_n_oe_o,
	input wire logic tag_oe_o,
	input wire logic standby_o,
	input wire logic slow_ov_only_o,
	input wire logic timer_run_o,
	input wire logic sleep_entry_o,
	input wire logic sleep_exit_o
);
	// Check plus fuse load, with slack for the state changes
	localparam int FAIL_MAX = CHECK_LEN + 40;
	logic [7:0] la_reg, la_next, lb_reg, lb_next;
	logic tr_reg, exp_reg, exp_next, wok, ctl_lk;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_out_n_i);
	assign wok = wr_i && bus_active_o && bank_one_i;
	assign ctl_lk = la_reg[wp_pkg::LOCK_CONTROL] && lb_reg[wp_pkg::LOCK_CONTROL];
	// Lock shadow: bits only set, cleared by unlock-all unless control is guarded
	always_comb begin
		la_next = la_reg;
		lb_next = lb_reg;
		exp_next = (exp_reg || (tr_reg && !timer_run_o)) && run_req_i;
		if (wok && addr_i == wp_pkg::OFS_WRITE_LOCK_A)
			la_next = la_reg | (wdata_i & wp_pkg::LOCK_MASK);
		if (wok && addr_i == wp_pkg::OFS_WRITE_LOCK_B)
			lb_next = lb_reg | (wdata_i & wp_pkg::LOCK_MASK);
		if (wok && addr_i == wp_pkg::OFS_SUPERVISOR_CTRL && wdata_i[wp_pkg::CTRL_UNLOCK_ALL] && !ctl_lk) begin
			la_next = wp_pkg::LOCK_RESET;
			lb_next = wp_pkg::LOCK_RESET;
		end
	end
	// Shadow registers
	always_ff @(posedge clk_i) begin
		if (!reset_out_n_i) begin
			la_reg <= wp_pkg::LOCK_RESET;
			lb_reg <= wp_pkg::LOCK_RESET;
			tr_reg <= 1'b0;
			exp_reg <= 1'b0;
		end else begin
			la_reg <= la_next;
			lb_reg <= lb_next;
			tr_reg <= timer_run_o;
			exp_reg <= exp_next;
		end
	end
	check_outputs_a: assert property (!bus_active_o && !fault_irq_n_oe_o |-> reset_out_n_oe_o && !tag_oe_o)
		else $error("outputs wrong while port inactive");
	standby_mode_a: assert property (standby_o |-> slow_ov_only_o && bus_active_o)
		else $error("standby without slow check or port");
	standby_leave_a: assert property ($rose(timer_run_o) |-> ##[0:4] !standby_o)
		else $error("standby kept while running");
	timer_start_a: assert property ($rose(run_req_i) && standby_o |-> ##[1:8] timer_run_o)
		else $error("timer not started on run");
	sleep_gate_a: assert property (sleep_entry_o || sleep_exit_o |-> exp_reg)
		else $error("low-power pin acted on too early");
	sleep_pulse_a: assert property (sleep_entry_o |=> !sleep_entry_o && !sleep_exit_o)
		else $error("sleep entry not a single pulse");
	lock_read_a: assert property (rd_i && bus_active_o && bank_one_i && addr_i == wp_pkg::OFS_WRITE_LOCK_A
		|=> (rdata_o & wp_pkg::LOCK_MASK) == la_reg) else $error("lock read differs from shadow");
	fail_out_a: assert property (check_fail_i && !bus_active_o |-> ##[1:FAIL_MAX] fault_irq_n_oe_o && reset_out_n_oe_o)
		else $error("failure outputs missing");
	cover property (sleep_entry_o);
	cover property ($fell(bus_active_o));
	cover property (fault_irq_n_oe_o && reset_out_n_oe_o);
endmodule

bind wp_startup wp_startup_chk #(.CHECK_LEN(CHECK_LEN)) chk_u (.clk_i, .reset_out_n_i, .bank_one_i, .addr_i, .wdata_i,
	.wr_i, .rd_i, .check_fail_i, .run_req_i, .rdata_o, .bus_active_o, .fault_irq_n_oe_o, .reset_out_n_oe_o,
	.tag_oe_o, .standby_o, .slow_ov_only_o, .timer_run_o, .sleep_entry_o, .sleep_exit_o);

// ---- wp_host_model.sv ----
/*
 * Host model for the byte register port: one-cycle write and read strobes.
 * Assumes the bench calls it only while the port is active.
 */
`timescale 1ns/1ns
module wp_host_model (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	// Idle port at time zero
	initial begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Idle lines show the inverse so stale values are never mistaken for data
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	// Read data stands from the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_i);
		d = rdata_i;
	endtask
endmodule

// ---- write_protect_and_selftest_startup_test.sv ----
/*
 * Self-checking bench for wp_startup: lock table, start-up, run and failure.
 * Assumes wp_pkg, the host model and the checker are compiled first.
 */
`timescale 1ns/1ns
module write_protect_and_selftest_startup_test;
	logic clk_i, reset_out_n_i, bank_one_i, check_fail_i, run_req_i, low_power_n_i, wr_i, rd_i;
	logic [7:0] addr_i, wdata_i, rdata_o, d;
	logic bus_active_o, fault_irq_n_o, fault_irq_n_oe_o, reset_out_n_o, reset_out_n_oe_o, tag_oe_o;
	logic standby_o, slow_ov_only_o, timer_run_o, sleep_entry_o, sleep_exit_o;
	int failures, num_checks, cyc, n_ent, n_ext, j;
	// Rows: top nibble 1 writes, 0 reads and expects; then offset, data
	localparam logic [19:0] ROWS [0:31] = '{
		20'h0_F100, 20'h0_F200, 20'h0_F3FF, 20'h1_F3FE,
		20'h0_F3FE, 20'h1_38AA, 20'h1_F10A, 20'h0_F10A,
		20'h1_113C, 20'h0_113C, 20'h1_F20A, 20'h0_F20A,
		20'h1_11C3, 20'h0_113C, 20'h1_3077, 20'h0_3077,
		20'h1_3855, 20'h0_38AA, 20'h1_F100, 20'h0_F10A,
		20'h1_1008, 20'h0_F100, 20'h0_F200, 20'h1_11A5,
		20'h0_11A5, 20'h1_F1E0, 20'h1_F220, 20'h0_F120,
		20'h1_1008, 20'h0_F120, 20'h0_F220, 20'h0_F3FE};
	wp_startup #(.CHECK_LEN(8)) uut (.clk_i, .reset_out_n_i, .bank_one_i, .addr_i, .wdata_i, .wr_i, .rd_i, .check_fail_i,
		.run_req_i, .low_power_n_i, .rdata_o, .bus_active_o, .fault_irq_n_o, .fault_irq_n_oe_o, .reset_out_n_o,
		.reset_out_n_oe_o, .tag_oe_o, .standby_o, .slow_ov_only_o, .timer_run_o, .sleep_entry_o, .sleep_exit_o);
	wp_host_model host (.clk_i, .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		if (failures == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// 4 ns clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// Sleep pulse counts and hang guard, sampled where outputs are settled
	always @(negedge clk_i) begin
		cyc++;
		n_ent += sleep_entry_o;
		n_ext += sleep_exit_o;
		if (cyc == 5000) begin
			failures++;
			final_report;
		end
	end
	// Main sequence
	initial begin
		reset_out_n_i = 1'b0;
		bank_one_i = 1'b1;
		check_fail_i = 1'b0;
		run_req_i = 1'b0;
		low_power_n_i = 1'b1;
		repeat (3) @(posedge clk_i);
		reset_out_n_i <= 1'b1;
		@(negedge clk_i);
		chk({4'h0, bus_active_o, reset_out_n_oe_o, tag_oe_o, fault_irq_n_oe_o}, 8'h04);
		for (j = 0; j < 200 && standby_o !== 1'b1; j++) @(negedge clk_i);
		chk({6'h00, bus_active_o, slow_ov_only_o}, 8'h03);
		host.rd(wp_pkg::OFS_SUPERVISOR_STATUS, d);
		chk(d & 8'h03, 8'h01);
		host.rd(wp_pkg::OFS_SELFTEST_RESULT, d);
		chk(d & 8'h0F, 8'h08);
		chk({7'h00, fault_irq_n_oe_o}, 8'h01);
		foreach (ROWS[k]) begin
			if (ROWS[k][16])
				host.wr(ROWS[k][15:8], ROWS[k][7:0]);
			else begin
				host.rd(ROWS[k][15:8], d);
				chk(d, ROWS[k][7:0]);
			end
		end
		// Short order timeout of 250 cycles, check on shutdown enabled
		host.wr(wp_pkg::OFS_ORDER_TIMEOUT_HI, 8'h00);
		host.wr(wp_pkg::OFS_ORDER_TIMEOUT_LO, 8'h01);
		host.wr(wp_pkg::OFS_SELFTEST_SETUP, 8'h03);
		@(posedge clk_i);
		run_req_i <= 1'b1;
		for (j = 0; j < 20 && timer_run_o !== 1'b1; j++) @(negedge clk_i);
		chk({7'h00, timer_run_o}, 8'h01);
		chk({7'h00, standby_o}, 8'h00);
		@(posedge clk_i);
		low_power_n_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		low_power_n_i <= 1'b1;
		for (j = 0; j < 400 && timer_run_o !== 1'b0; j++) @(negedge clk_i);
		chk(8'(n_ent + n_ext), 8'h00);
		@(posedge clk_i);
		low_power_n_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		low_power_n_i <= 1'b1;
		repeat (10) @(negedge clk_i);
		chk({n_ent[3:0], n_ext[3:0]}, 8'h11);
		@(posedge clk_i);
		run_req_i <= 1'b0;
		for (j = 0; j < 20 && bus_active_o !== 1'b0; j++) @(negedge clk_i);
		chk({7'h00, bus_active_o}, 8'h00);
		for (j = 0; j < 200 && standby_o !== 1'b1; j++) @(negedge clk_i);
		chk({7'h00, standby_o}, 8'h01);
		// Bank zero write passes a config lock, bank one write does not
		host.wr(wp_pkg::OFS_WRITE_LOCK_A, 8'h08);
		host.wr(wp_pkg::OFS_WRITE_LOCK_B, 8'h08);
		bank_one_i <= 1'b0;
		host.wr(wp_pkg::OFS_SUPERVISOR_MISC, 8'h5A);
		bank_one_i <= 1'b1;
		host.rd(wp_pkg::OFS_SUPERVISOR_MISC, d);
		chk(d, 8'h5A);
		host.wr(wp_pkg::OFS_SUPERVISOR_MISC, 8'h00);
		host.rd(wp_pkg::OFS_SUPERVISOR_MISC, d);
		chk(d, 8'h5A);
		// Second reset with a failing check: failsafe outputs
		@(posedge clk_i);
		check_fail_i <= 1'b1;
		reset_out_n_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		reset_out_n_i <= 1'b1;
		repeat (60) @(negedge clk_i);
		chk({6'h00, fault_irq_n_oe_o, reset_out_n_oe_o}, 8'h03);
		chk({6'h00, fault_irq_n_o, reset_out_n_o}, 8'h00);
		final_report;
	end
endmodule
